// file: hw/mccd_ctl_regs.sv
// Control register file reached by control-file moves
`timescale 1ns/1ns
`default_nettype none
module mccd_ctl_regs
  import mccd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wr_en_i,
  input  wire logic [4:0]  wr_addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic [4:0]  rd_addr_i,
  input  wire logic [31:0] exec_pc_i,
  input  wire logic [31:0] irq_event_i,
  output logic      [31:0] rd_data_o,
  output logic      [31:0] amode_o,
  output logic      [31:0] cstat_o,
  output logic      [31:0] iflag_o,
  output logic      [31:0] ien_o,
  output logic      [31:0] stp_o,
  output logic      [31:0] iret_ptr_o,
  output logic      [31:0] nmret_ptr_o
);

  logic [31:0] set_bits;
  logic [31:0] clr_bits;

  always_comb begin
    case (rd_addr_i)
      MCCD_ADDR_AMODE: rd_data_o = amode_o;
      MCCD_ADDR_CSTAT: rd_data_o = cstat_o;
      MCCD_ADDR_IFLAG: rd_data_o = iflag_o;
      MCCD_ADDR_IEN:   rd_data_o = ien_o;
      MCCD_ADDR_STP:   rd_data_o = stp_o;
      MCCD_ADDR_IRET:  rd_data_o = iret_ptr_o;
      MCCD_ADDR_NMRET: rd_data_o = nmret_ptr_o;
      MCCD_ADDR_PC:    rd_data_o = exec_pc_i;
      default:         rd_data_o = MCCD_NO_VALUE;
    endcase
  end

  // Flag set and clear; an event wins over a clear in the same cycle
  assign set_bits = irq_event_i | ((wr_en_i && wr_addr_i == MCCD_ADDR_IFLAG) ? wr_data_i : MCCD_REG_RESET);
  assign clr_bits = (wr_en_i && wr_addr_i == MCCD_ADDR_ICLR) ? wr_data_i : MCCD_REG_RESET;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iflag_o <= MCCD_REG_RESET;
    end else if (ce_i) begin
      iflag_o <= (iflag_o & ~clr_bits) | set_bits;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amode_o <= MCCD_REG_RESET;
      cstat_o <= MCCD_REG_RESET;
      ien_o   <= MCCD_REG_RESET;
      stp_o   <= MCCD_REG_RESET;
      iret_ptr_o  <= MCCD_REG_RESET;
      nmret_ptr_o <= MCCD_REG_RESET;
    end else if (ce_i && wr_en_i) begin
      case (wr_addr_i)
        MCCD_ADDR_AMODE: amode_o <= (amode_o & ~MCCD_AMODE_WMASK) | (wr_data_i & MCCD_AMODE_WMASK);
        MCCD_ADDR_CSTAT: cstat_o <= wr_data_i;
        MCCD_ADDR_IEN:   ien_o   <= wr_data_i;
        MCCD_ADDR_STP:   stp_o   <= wr_data_i;
        MCCD_ADDR_IRET:  iret_ptr_o  <= wr_data_i;
        MCCD_ADDR_NMRET: nmret_ptr_o <= wr_data_i;
        default: ; // Read-only and unmapped writes are dropped
      endcase
    end
  end

  amode_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_en_i && wr_addr_i == MCCD_ADDR_AMODE |=> amode_o[31:26] == $past(amode_o[31:26]))
    else $error("reserved mode bits were written");

  flag_set_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_en_i && wr_addr_i == MCCD_ADDR_ICLR && irq_event_i == MCCD_REG_RESET
    |=> (iflag_o & $past(wr_data_i)) == MCCD_REG_RESET)
    else $error("flag clear did not clear the flags");

endmodule : mccd_ctl_regs
`default_nettype wire

// file: hw/mccd_move_decode.sv
// Decode and execute of register copy, control-file move and constant loads
//
// Behaviour
// - Register copy adds zero, single cycle
// - Opfield 001111 reads control register to general
// - Opfield 001110 writes general source to control
// - Control moves only on side B shift unit
// - Mode, status, enable registers at 0,1,4
// - Address 2 reads flags, writes set; 3 clears
// - Address 10000 reads first execute phase PC
// - Table and return pointers at 5,6,7
// - Top six mode bits never written
// - Upper insert keeps destination low half
// - Low load equals signed load; pairs with insert
`timescale 1ns/1ns
`default_nettype none
module mccd_move_decode
  import mccd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        instr_valid_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [31:0] src_data_i,
  input  wire logic [31:0] dst_data_i,
  input  wire logic [31:0] cond_data_i,
  input  wire logic [31:0] exec_pc_i,
  input  wire logic [31:0] irq_event_i,
  output logic             wr_en_o,
  output logic             wr_side_o,
  output logic      [4:0]  wr_addr_o,
  output logic      [31:0] wr_data_o,
  output logic             unsupported_o,
  output logic      [31:0] amode_o,
  output logic      [31:0] cstat_o,
  output logic      [31:0] iflag_o,
  output logic      [31:0] ien_o,
  output logic      [31:0] stp_o,
  output logic      [31:0] iret_ptr_o,
  output logic      [31:0] nmret_ptr_o
);

  // Classify one instruction word into the operation it asks for
  function automatic mccd_op_e mccd_classify(input logic [31:0] w);
    logic zero_src1;
    zero_src1 = (w[MCCD_SRC1_MSB:MCCD_SRC1_LSB] == MCCD_SRC1_ZERO);
    if (w[4:2] == MCCD_L_TAIL && zero_src1 && (w[11:5] == MCCD_L_ADD_INT || w[11:5] == MCCD_L_ADD_LONG)) begin
      mccd_classify = MCCD_OP_COPY;
    end else if (w[5:2] == MCCD_S_TAIL && zero_src1 && w[11:6] == MCCD_S_ADD_OP) begin
      mccd_classify = MCCD_OP_COPY;
    end else if (w[5:2] == MCCD_S_TAIL && zero_src1 && w[11:6] == MCCD_CTL_RD_OP) begin
      mccd_classify = MCCD_OP_CTL_RD;
    end else if (w[5:2] == MCCD_S_TAIL && zero_src1 && w[11:6] == MCCD_CTL_WR_OP) begin
      mccd_classify = MCCD_OP_CTL_WR;
    end else if (w[6:2] == MCCD_D_TAIL && zero_src1 && w[12:7] == MCCD_D_ADD_OP) begin
      mccd_classify = MCCD_OP_COPY;
    end else if (w[6:2] == MCCD_CONST_TAIL) begin
      mccd_classify = MCCD_OP_CONST;
    end else if (w[6:2] == MCCD_UPPER_TAIL) begin
      mccd_classify = MCCD_OP_UPPER;
    end else begin
      mccd_classify = MCCD_OP_NONE;
    end
  endfunction : mccd_classify

  // Condition test; a zero condition field means always
  function automatic logic mccd_pred(input logic [2:0] creg, input logic zflag, input logic [31:0] val);
    if (creg == 3'h0) begin
      mccd_pred = 1'b1;
    end else if (zflag) begin
      mccd_pred = (val == 32'h0000_0000);
    end else begin
      mccd_pred = (val != 32'h0000_0000);
    end
  endfunction : mccd_pred

  // Sign extension of a sixteen-bit field
  function automatic logic [31:0] mccd_sext16(input logic [15:0] c);
    mccd_sext16 = {{16{c[15]}}, c};
  endfunction : mccd_sext16

  mccd_op_e    op;
  logic        pred_ok;
  logic        on_side_b;
  logic        ctl_ok;
  logic [15:0] cst;
  logic [4:0]  dst_field;
  logic [4:0]  src_field;
  logic        ctl_wr;
  logic [31:0] ctl_rd_data;
  logic        wr_en_nxt;
  logic [31:0] wr_data_nxt;

  assign op         = instr_valid_i ? mccd_classify(instr_i) : MCCD_OP_NONE;
  assign pred_ok    = mccd_pred(instr_i[MCCD_CREG_MSB:MCCD_CREG_LSB], instr_i[MCCD_Z_BIT], cond_data_i);
  assign on_side_b  = instr_i[MCCD_SIDE_BIT];
  assign ctl_ok     = on_side_b;
  assign cst        = instr_i[MCCD_CST_MSB:MCCD_CST_LSB];
  assign dst_field  = instr_i[MCCD_DST_MSB:MCCD_DST_LSB];
  assign src_field  = instr_i[MCCD_SRC_MSB:MCCD_SRC_LSB];

  // Source arrives already routed over the cross path when x is set
  assign ctl_wr = (op == MCCD_OP_CTL_WR) && ctl_ok && pred_ok;

  mccd_ctl_regs u_ctl_regs (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .wr_en_i     (ctl_wr),
    .wr_addr_i   (dst_field),
    .wr_data_i   (src_data_i),
    .rd_addr_i   (src_field),
    .exec_pc_i   (exec_pc_i),
    .irq_event_i (irq_event_i),
    .rd_data_o   (ctl_rd_data),
    .amode_o     (amode_o),
    .cstat_o     (cstat_o),
    .iflag_o     (iflag_o),
    .ien_o       (ien_o),
    .stp_o       (stp_o),
    .iret_ptr_o  (iret_ptr_o),
    .nmret_ptr_o (nmret_ptr_o)
  );

  always_comb begin
    wr_en_nxt   = 1'b0;
    wr_data_nxt = MCCD_NO_VALUE;
    case (op)
      MCCD_OP_COPY: begin
        wr_en_nxt   = pred_ok;
        wr_data_nxt = src_data_i + MCCD_ADD_ZERO;
      end
      MCCD_OP_CTL_RD: begin
        wr_en_nxt   = pred_ok && ctl_ok;
        wr_data_nxt = ctl_rd_data;
      end
      MCCD_OP_CONST: begin
        // Low load shares this encoding, so it behaves identically
        wr_en_nxt   = pred_ok;
        wr_data_nxt = mccd_sext16(cst);
      end
      MCCD_OP_UPPER: begin
        wr_en_nxt   = pred_ok;
        wr_data_nxt = {cst, dst_data_i[15:0]};
      end
      MCCD_OP_CTL_WR,
      MCCD_OP_NONE: begin
        wr_en_nxt   = 1'b0;
        wr_data_nxt = MCCD_NO_VALUE;
      end
      default: begin
        wr_en_nxt   = 1'b0;
        wr_data_nxt = MCCD_NO_VALUE;
      end
    endcase
  end

  // General register write port, one cycle after issue
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_en_o   <= 1'b0;
      wr_side_o <= 1'b0;
      wr_addr_o <= 5'h00;
      wr_data_o <= MCCD_NO_VALUE;
    end else if (ce_i) begin
      wr_en_o   <= wr_en_nxt;
      wr_side_o <= on_side_b;
      wr_addr_o <= dst_field;
      wr_data_o <= wr_data_nxt;
    end
  end

  // Control move issued on a unit that cannot carry it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unsupported_o <= 1'b0;
    end else if (ce_i) begin
      unsupported_o <= (op == MCCD_OP_CTL_RD || op == MCCD_OP_CTL_WR) && !ctl_ok;
    end
  end

  copy_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_COPY && pred_ok |=> wr_en_o && wr_data_o == $past(src_data_i))
    else $error("register copy result wrong");

  ctl_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_CTL_RD && pred_ok && ctl_ok |=> wr_en_o && wr_data_o == $past(ctl_rd_data)
      && wr_side_o)
    else $error("control read result wrong");

  ctl_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ctl_wr && dst_field == MCCD_ADDR_IEN |=> ien_o == $past(src_data_i) && !wr_en_o)
    else $error("control write did not land");

  side_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (op == MCCD_OP_CTL_RD || op == MCCD_OP_CTL_WR) && !on_side_b
    |=> unsupported_o && !wr_en_o && $stable(ien_o) && $stable(amode_o))
    else $error("control move accepted off side B");

  exec_pc_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_CTL_RD && ctl_ok && pred_ok && src_field == MCCD_ADDR_PC
    |=> wr_data_o == $past(exec_pc_i))
    else $error("execute phase PC read wrong");

  sign_ext_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_CONST && pred_ok |=> wr_en_o && wr_data_o[31:16] == {16{$past(cst[15])}}
      && wr_data_o[15:0] == $past(cst))
    else $error("constant load not sign extended");

  upper_insert_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_UPPER && pred_ok |=> wr_data_o[15:0] == $past(dst_data_i[15:0])
      && wr_data_o[31:16] == $past(cst))
    else $error("upper insert disturbed low half");

  pred_false_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !pred_ok |=> !wr_en_o)
    else $error("write made under false predicate");

  ro_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ctl_wr && dst_field == MCCD_ADDR_PC |=> $stable(amode_o) && $stable(cstat_o) && $stable(ien_o)
      && $stable(stp_o) && $stable(iret_ptr_o) && $stable(nmret_ptr_o))
    else $error("read-only control write took effect");

  // Clock enable low freezes the write port and the control file
  ce_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(wr_en_o) && $stable(wr_data_o) && $stable(wr_addr_o)
      && $stable(wr_side_o) && $stable(unsupported_o))
    else $error("write port moved with clock enable low");

  ctl_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(amode_o) && $stable(cstat_o) && $stable(iflag_o) && $stable(ien_o)
      && $stable(stp_o) && $stable(iret_ptr_o) && $stable(nmret_ptr_o))
    else $error("control register moved with clock enable low");

  write_target_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> wr_addr_o == $past(dst_field) && wr_side_o == $past(on_side_b))
    else $error("write target register wrong");

  idle_no_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_NONE |=> !wr_en_o && !unsupported_o)
    else $error("write made without a move");

  ctl_wr_silent_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_CTL_WR |=> !wr_en_o)
    else $error("control write touched the general file");

  mode_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ctl_wr && dst_field == MCCD_ADDR_AMODE
    |=> (amode_o & MCCD_AMODE_WMASK) == ($past(src_data_i) & MCCD_AMODE_WMASK))
    else $error("mode register write lost");

  plain_no_unsup_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op != MCCD_OP_CTL_RD && op != MCCD_OP_CTL_WR |=> !unsupported_o)
    else $error("unsupported flagged for a plain move");

  // Control reads, one check per register group
  status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_CTL_RD && ctl_ok && pred_ok && src_field == MCCD_ADDR_CSTAT
    |=> wr_data_o == $past(cstat_o))
    else $error("status register read wrong");

  flag_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_CTL_RD && ctl_ok && pred_ok && src_field == MCCD_ADDR_IFLAG
    |=> wr_data_o == $past(iflag_o))
    else $error("flag register read wrong");

  ptr_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_CTL_RD && ctl_ok && pred_ok && src_field == MCCD_ADDR_STP
    |=> wr_data_o == $past(stp_o))
    else $error("table pointer read wrong");

  wo_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_CTL_RD && ctl_ok && pred_ok && src_field == MCCD_ADDR_ICLR
    |=> wr_data_o == MCCD_NO_VALUE)
    else $error("write-only read returned data");

  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ctl_wr && dst_field == MCCD_ADDR_IFLAG |=> (iflag_o & $past(src_data_i)) == $past(src_data_i))
    else $error("flag set lost a bit");

  ptr_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ctl_wr && dst_field == MCCD_ADDR_NMRET |=> nmret_ptr_o == $past(src_data_i))
    else $error("return pointer write lost");

  pred_ctl_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !pred_ok |=> $stable(ien_o) && $stable(cstat_o) && $stable(amode_o) && $stable(stp_o))
    else $error("control write made under false predicate");

  copy_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_COPY && pred_ok);

  ctl_write_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ctl_wr);

  const_pair_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op == MCCD_OP_CONST ##1 ce_i && op == MCCD_OP_UPPER);

  pred_skip_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && op != MCCD_OP_NONE && !pred_ok);

  unsup_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (op == MCCD_OP_CTL_RD || op == MCCD_OP_CTL_WR) && !ctl_ok);

endmodule : mccd_move_decode
`default_nettype wire

// file: hw/mccd_pkg.sv
// Constants and types shared by the move and constant-load decode block
package mccd_pkg;

  // Instruction field positions
  localparam int unsigned MCCD_CREG_MSB   = 31;
  localparam int unsigned MCCD_CREG_LSB   = 29;
  localparam int unsigned MCCD_Z_BIT      = 28;
  localparam int unsigned MCCD_DST_MSB    = 27;
  localparam int unsigned MCCD_DST_LSB    = 23;
  localparam int unsigned MCCD_SRC_MSB    = 22;
  localparam int unsigned MCCD_SRC_LSB    = 18;
  localparam int unsigned MCCD_SRC1_MSB   = 17;
  localparam int unsigned MCCD_SRC1_LSB   = 13;
  localparam int unsigned MCCD_CST_MSB    = 22;
  localparam int unsigned MCCD_CST_LSB    = 7;
  localparam int unsigned MCCD_SIDE_BIT   = 1;

  // Opcode patterns
  localparam logic [2:0] MCCD_L_TAIL      = 3'h6;
  localparam logic [6:0] MCCD_L_ADD_INT   = 7'h02;
  localparam logic [6:0] MCCD_L_ADD_LONG  = 7'h20;
  localparam logic [3:0] MCCD_S_TAIL      = 4'h8;
  localparam logic [5:0] MCCD_S_ADD_OP    = 6'h07;
  localparam logic [5:0] MCCD_CTL_RD_OP   = 6'h0f;
  localparam logic [5:0] MCCD_CTL_WR_OP   = 6'h0e;
  localparam logic [4:0] MCCD_D_TAIL      = 5'h10;
  localparam logic [5:0] MCCD_D_ADD_OP    = 6'h12;
  localparam logic [4:0] MCCD_CONST_TAIL  = 5'h0a;
  localparam logic [4:0] MCCD_UPPER_TAIL  = 5'h1a;
  localparam logic [4:0] MCCD_SRC1_ZERO   = 5'h00;
  localparam logic [31:0] MCCD_ADD_ZERO   = 32'h0000_0000;

  // Control register addresses
  localparam logic [4:0] MCCD_ADDR_AMODE  = 5'h00;
  localparam logic [4:0] MCCD_ADDR_CSTAT  = 5'h01;
  localparam logic [4:0] MCCD_ADDR_IFLAG  = 5'h02;
  localparam logic [4:0] MCCD_ADDR_ICLR   = 5'h03;
  localparam logic [4:0] MCCD_ADDR_IEN    = 5'h04;
  localparam logic [4:0] MCCD_ADDR_STP    = 5'h05;
  localparam logic [4:0] MCCD_ADDR_IRET   = 5'h06;
  localparam logic [4:0] MCCD_ADDR_NMRET  = 5'h07;
  localparam logic [4:0] MCCD_ADDR_PC     = 5'h10;

  // Reset values and masks
  localparam logic [31:0] MCCD_REG_RESET  = 32'h0000_0000;
  localparam logic [31:0] MCCD_AMODE_WMASK = 32'h03ff_ffff;
  localparam logic [31:0] MCCD_NO_VALUE   = 32'h0000_0000;

  // Decoded operation, one-hot
  typedef enum logic [5:0] {
    MCCD_OP_NONE   = 6'h01,
    MCCD_OP_COPY   = 6'h02,
    MCCD_OP_CTL_RD = 6'h04,
    MCCD_OP_CTL_WR = 6'h08,
    MCCD_OP_CONST  = 6'h10,
    MCCD_OP_UPPER  = 6'h20
  } mccd_op_e;

endpackage : mccd_pkg

// file: sim/mccd_dispatch_model.sv
// Dispatch stage model: general register files, operand fetch and write-back
`timescale 1ns/1ns
`default_nettype none
module mccd_dispatch_model
  import mccd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        issue_i,
  input  wire logic [31:0] word_i,
  input  wire logic        wr_en_i,
  input  wire logic        wr_side_i,
  input  wire logic [4:0]  wr_addr_i,
  input  wire logic [31:0] wr_data_i,
  output logic             instr_valid_o,
  output logic      [31:0] instr_o,
  output logic      [31:0] src_data_o,
  output logic      [31:0] dst_data_o,
  output logic      [31:0] cond_data_o
);
  logic [31:0] rf [0:63];
  logic        side;

  // Forwarding, so back-to-back pairs see the fresh value
  function automatic logic [31:0] fetch(input logic [5:0] idx);
    if (wr_en_i && {wr_side_i, wr_addr_i} == idx) begin
      return wr_data_i;
    end
    return rf[idx];
  endfunction : fetch

  assign side          = instr_o[MCCD_SIDE_BIT];
  assign instr_valid_o = issue_i;
  // Idle word is the inverse, never a stale copy
  assign instr_o       = issue_i ? word_i : ~word_i;

  always_comb begin
    src_data_o  = fetch({side ^ instr_o[12], instr_o[MCCD_SRC_MSB:MCCD_SRC_LSB]});
    dst_data_o  = fetch({side, instr_o[MCCD_DST_MSB:MCCD_DST_LSB]});
    // Condition registers sit at the bottom of the side B file
    cond_data_o = fetch({3'h4, instr_o[MCCD_CREG_MSB:MCCD_CREG_LSB]});
  end

  always @(posedge clk_i) begin
    if (wr_en_i) begin
      rf[{wr_side_i, wr_addr_i}] <= wr_data_i;
    end
  end
endmodule : mccd_dispatch_model
`default_nettype wire

// file: sim/test_mccd_move_decode.sv
// Bench for the move and constant-load decode block
`timescale 1ns/1ns
`default_nettype none
module test_mccd_move_decode
  import mccd_pkg::*;
;
  logic        clk_i, rst_i, ce_i, iss, valid, wr_en, wr_side, unsup;
  logic [4:0]  wr_addr;
  logic [31:0] word, instr, src_d, dst_d, cond_d, pc, irq, wr_data, v;
  logic [31:0] amode, cstat, iflag, ien, stp, iret_ptr, nmret_ptr;
  logic [4:0]  rw [0:5] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07};
  int          failures, samples_checked, i;

  mccd_move_decode i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .instr_valid_i(valid), .instr_i(instr),
    .src_data_i(src_d), .dst_data_i(dst_d), .cond_data_i(cond_d), .exec_pc_i(pc),
    .irq_event_i(irq), .wr_en_o(wr_en), .wr_side_o(wr_side), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .unsupported_o(unsup), .amode_o(amode), .cstat_o(cstat),
    .iflag_o(iflag), .ien_o(ien), .stp_o(stp), .iret_ptr_o(iret_ptr), .nmret_ptr_o(nmret_ptr));

  mccd_dispatch_model i_model (
    .clk_i(clk_i), .issue_i(iss), .word_i(word), .wr_en_i(wr_en), .wr_side_i(wr_side),
    .wr_addr_i(wr_addr), .wr_data_i(wr_data), .instr_valid_o(valid), .instr_o(instr),
    .src_data_o(src_d), .dst_data_o(dst_d), .cond_data_o(cond_d));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic op(input logic [31:0] w);
    @(negedge clk_i);
    iss  = 1'b1;
    word = w;
  endtask : op

  // Drop the request, then let the write-back edge pass
  task automatic fin();
    @(negedge clk_i);
    iss = 1'b0;
    @(negedge clk_i);
  endtask : fin

  function automatic logic [31:0] ws(input logic [5:0] o, input logic [4:0] d, s2, input logic sb);
    return {4'h0, d, s2, 6'h00, o, MCCD_S_TAIL, sb, 1'b0};
  endfunction : ws

  function automatic logic [31:0] wk(input logic [3:0] cz, input logic [4:0] t, d, input logic [15:0] k);
    return {cz, d, k, t, 2'b10};
  endfunction : wk

  function automatic logic [31:0] ctl_out(input logic [4:0] a);
    case (a)
      5'h00:   return amode;
      5'h01:   return cstat;
      5'h04:   return ien;
      5'h05:   return stp;
      5'h06:   return iret_ptr;
      default: return nmret_ptr;
    endcase
  endfunction : ctl_out

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    failures++;
    complete_run();
  end

  initial begin
    rst_i = 1'b1;
    ce_i  = 1'b1;
    iss   = 1'b0;
    word  = 32'h0;
    pc    = 32'h1234_5678;
    irq   = 32'h0;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    chk("reset write enable", {31'h0, wr_en}, 32'h0);
    chk("reset flags", iflag, MCCD_REG_RESET);
    // Constant loads back to back, the insert reading a just-written register
    i_model.rf[40] = 32'hdead_beef;
    op(wk(4'h0, MCCD_CONST_TAIL, 5'd5, 16'h8001));
    op(wk(4'h0, MCCD_CONST_TAIL, 5'd6, 16'h7fff));
    op(wk(4'h0, MCCD_CONST_TAIL, 5'd7, 16'h8001));
    op(wk(4'h0, MCCD_UPPER_TAIL, 5'd5, 16'h1234));
    op(wk(4'h0, MCCD_UPPER_TAIL, 5'd8, 16'h0a32));
    fin();
    chk("positive load", i_model.rf[38], 32'h0000_7fff);
    chk("negative load", i_model.rf[39], 32'hffff_8001);
    chk("constant pair", i_model.rf[37], 32'h1234_8001);
    chk("upper insert", i_model.rf[40], 32'h0a32_beef);
    i_model.rf[3]  = 32'h1111_2222;
    i_model.rf[35] = 32'h3333_4444;
    op({4'h0, 5'd9, 5'd3, 6'h00, MCCD_L_ADD_INT, MCCD_L_TAIL, 2'b00});
    @(negedge clk_i);
    iss = 1'b0;
    chk("copy write enable", {31'h0, wr_en}, 32'h1);
    chk("copy data", wr_data, 32'h1111_2222);
    chk("copy target", {26'h0, wr_side, wr_addr}, 32'h0000_0009);
    @(negedge clk_i);
    chk("copy single pulse", {31'h0, wr_en}, 32'h0);
    // Long-form copy, its result held while clock enable is low
    op({4'h0, 5'd15, 5'd3, 6'h00, MCCD_L_ADD_LONG, MCCD_L_TAIL, 2'b00});
    @(negedge clk_i);
    iss  = 1'b0;
    ce_i = 1'b0;
    @(negedge clk_i);
    ce_i = 1'b1;
    chk("frozen long copy", wr_data, 32'h1111_2222);
    chk("frozen write enable", {31'h0, wr_en}, 32'h1);
    @(negedge clk_i);
    chk("thawed write enable", {31'h0, wr_en}, 32'h0);
    op({4'h0, 5'd10, 5'd3, 6'h01, MCCD_S_ADD_OP, MCCD_S_TAIL, 2'b10});
    op({4'h0, 5'd11, 5'd3, 5'h00, MCCD_D_ADD_OP, MCCD_D_TAIL, 2'b10});
    fin();
    chk("cross path copy", i_model.rf[42], 32'h1111_2222);
    chk("data unit copy", i_model.rf[43], 32'h3333_4444);
    for (i = 0; i < 6; i++) begin
      v = 32'hf009_0001 + 32'(i);
      i_model.rf[52] = v;
      op(ws(MCCD_CTL_WR_OP, rw[i], 5'd20, 1'b1));
      fin();
      op(ws(MCCD_CTL_RD_OP, 5'd21, rw[i], 1'b1));
      fin();
      if (i == 0) begin
        v = v & 32'h03ff_ffff;
      end
      chk("control register", ctl_out(rw[i]), v);
      chk("control read back", i_model.rf[53], v);
    end
    i_model.rf[52] = 32'h0000_00ff;
    op(ws(MCCD_CTL_WR_OP, 5'h02, 5'd20, 1'b1));
    fin();
    chk("flag set", iflag, 32'h0000_00ff);
    i_model.rf[52] = 32'h0000_000f;
    op(ws(MCCD_CTL_WR_OP, 5'h03, 5'd20, 1'b1));
    fin();
    chk("flag clear", iflag, 32'h0000_00f0);
    irq = 32'h0000_0100;
    @(negedge clk_i);
    irq = 32'h0;
    op(ws(MCCD_CTL_RD_OP, 5'd21, 5'h02, 1'b1));
    op(ws(MCCD_CTL_RD_OP, 5'd22, 5'h03, 1'b1));
    op(ws(MCCD_CTL_RD_OP, 5'd23, 5'h10, 1'b1));
    op(ws(MCCD_CTL_WR_OP, 5'h10, 5'd20, 1'b1));
    op(ws(MCCD_CTL_WR_OP, 5'h04, 5'd20, 1'b0));
    @(negedge clk_i);
    iss = 1'b0;
    chk("side A control move", {31'h0, unsup}, 32'h1);
    @(negedge clk_i);
    chk("flag read", i_model.rf[53], 32'h0000_01f0);
    chk("clear read", i_model.rf[54], MCCD_NO_VALUE);
    chk("pc read", i_model.rf[55], 32'h1234_5678);
    chk("enable kept", ien, 32'hf009_0003);
    i_model.rf[33] = 32'h0000_0005;
    i_model.rf[44] = 32'h5555_5555;
    op(wk(4'h3, MCCD_CONST_TAIL, 5'd12, 16'h0042));
    op(wk(4'h2, MCCD_CONST_TAIL, 5'd13, 16'h0042));
    fin();
    chk("false predicate", i_model.rf[44], 32'h5555_5555);
    chk("true predicate", i_model.rf[45], 32'h0000_0042);
    complete_run();
  end
endmodule : test_mccd_move_decode
`default_nettype wire
